// ---- rtl/ecc_pkg.sv ----
// Package for the encoder configuration, calibration and status block.
// Assumes a single 20 MHz device clock and a power-up reset.
package ecc_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [6:0] ADDR_INTERP_HI = 7'h0b;
    localparam logic [6:0] ADDR_INTERP_LO = 7'h0c;
    localparam logic [6:0] ADDR_COMMIT = 7'h11;
    localparam logic [7:0] COMMIT_KEY = 8'ha1;
    localparam int FRAME_BITS = 16;
    localparam int CMD_BIT = 15;
    localparam int HI_FACTOR_MSB = 2;
    localparam int WCODE_LSB = 6;
    localparam logic [10:0] FACTOR_MAX = 11'h400;
    localparam logic [10:0] FACTOR_RESET = 11'h001;
    localparam logic [10:0] FACTOR_1X = 11'h001;
    localparam logic [7:0] STAGE_HI_RESET = 8'h00;
    localparam logic [7:0] STAGE_LO_RESET = 8'h01;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [1:0] WCODE_90 = 2'h0;
    localparam logic [1:0] WCODE_180 = 2'h1;
    localparam logic [1:0] WCODE_BAD = 2'h2;
    localparam logic [1:0] WCODE_360 = 2'h3;

    typedef enum logic [1:0] {
        ECC_GATE_90 = 2'h0,
        ECC_GATE_180 = 2'h1,
        ECC_GATE_RAW = 2'h2,
        ECC_GATE_360 = 2'h3
    } ecc_gate_e;

    ////////////////////////////////////////////////////////////////////////
    localparam int CLK_HZ = 20000000;
    localparam int BLINK_PERIOD_MS = 500;
    localparam int BLINK_HALF_CYCLES = CLK_HZ / 1000 * BLINK_PERIOD_MS / 2;

    typedef enum logic [2:0] {
        ECC_PWR = 3'h0,
        ECC_RUN = 3'h1,
        ECC_INC = 3'h3,
        ECC_DONE = 3'h2,
        ECC_ERR = 3'h6,
        ECC_NORM = 3'h4
    } ecc_cal_e;

    // Order: a_pos, a_neg, b_pos, b_neg, i_pos, i_neg.
    typedef struct packed {
        logic a_pos;
        logic a_neg;
        logic b_pos;
        logic b_neg;
        logic i_pos;
        logic i_neg;
    } ecc_quad_s;

    localparam ecc_quad_s QUAD_FAULT = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

    typedef struct packed {
        logic inc_done;
        logic idx_done;
        logic failed;
    } ecc_cal_evt_s;

endpackage

// ---- rtl/ecc_core.sv ----
// Configuration, autocalibration and status logic of the encoder.
// Assumes SPI pins, calibration events and the raw channels are synchronous
// to clk; rst is the power-up reset, so a new calibration needs a new reset.
//
// Functional notes
// - Factor is 11 bits: 0x0B low three bits high part, 0x0C low byte.
// - Factor is plain binary; 256 is 0x0B bit 0, 1024 is bit 2.
// - Width code 00 gates 90, 01 gates 180, 11 gates 360 degrees.
// - At 1X no 360 gating; raw 330 degree index is used instead.
// - Calibration starts at power-up only with calibration request high.
// - Calibration progress shows on positive outputs: none, A, then B.
// - Failed calibration drives A and B positive high, index low.
// - Normal operation returns only after request removal and power cycle.
// - Calibration indicator blinks 500 ms running, high done, low else.
// - Status pins low at power-up; ready only in encoder-ready state.
// - Fault steady high at maximum light current, blinks on early warning.
// - Off-scale light fault forces a fixed differential output pattern.
// - Frames are 16 bits: command, 7-bit address, 8 data bits.
`timescale 1ns/100ps

module ecc_core #(
    parameter logic [23:0] BLINK_HALF = 24'(ecc_pkg::BLINK_HALF_CYCLES)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic spi_sel_n,
    input wire logic spi_sclk,
    input wire logic spi_din,
    output logic spi_dout,
    input wire logic calib_request,
    input wire ecc_pkg::ecc_cal_evt_s cal_evt,
    input wire logic light_max_current,
    input wire logic light_high_warn,
    input wire logic raw_a,
    input wire logic raw_b,
    input wire logic raw_index,
    output ecc_pkg::ecc_quad_s quad_out,
    output logic [10:0] interp_factor,
    output ecc_pkg::ecc_gate_e index_gate,
    output logic cfg_commit,
    output logic ready_indicator,
    output logic calib_indicator,
    output logic fault_indicator
);

    typedef struct packed {
        ecc_pkg::ecc_cal_e cal;
        logic sclk_q;
        logic [15:0] sh;
        logic [4:0] bits;
        logic [7:0] rd_sh;
        logic dout;
        logic [7:0] stage_hi;
        logic [7:0] stage_lo;
        logic [10:0] factor;
        logic [1:0] wcode;
        logic commit;
        logic [23:0] blink_cnt;
        logic blink;
        ecc_pkg::ecc_quad_s quad;
        logic ready;
        logic cal_ind;
        logic fault;
    } ecc_state_s;

    ecc_state_s st_r;
    ecc_state_s st_nxt;
    logic rise;
    logic fall;
    logic [15:0] word;
    logic [10:0] cand_factor;
    logic [1:0] cand_code;
    logic cand_write;

    assign rise = spi_sclk && !st_r.sclk_q;
    assign fall = !spi_sclk && st_r.sclk_q;
    assign word = {st_r.sh[14:0], spi_din};

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sclk_q = spi_sclk;
        st_nxt.commit = 1'b0;
        cand_factor = {st_r.stage_hi[ecc_pkg::HI_FACTOR_MSB:0], st_r.stage_lo};
        cand_code = st_r.stage_hi[ecc_pkg::WCODE_LSB +: 2];
        cand_write = 1'b0;
        if (spi_sel_n)
        begin
            st_nxt.bits = '0;
        end
        else if (rise && st_r.bits < 5'(ecc_pkg::FRAME_BITS))
        begin
            st_nxt.sh = word;
            st_nxt.bits = st_r.bits + 5'h01;
            if (st_r.bits == 5'h07 && !word[7])
            begin
                unique case (word[6:0])
                    ecc_pkg::ADDR_INTERP_HI: st_nxt.rd_sh = st_r.stage_hi;
                    ecc_pkg::ADDR_INTERP_LO: st_nxt.rd_sh = st_r.stage_lo;
                    default: st_nxt.rd_sh = 8'h00;
                endcase
            end
            if (st_r.bits == 5'(ecc_pkg::FRAME_BITS - 1)
                && word[ecc_pkg::CMD_BIT])
            begin
                if (word[14:8] == ecc_pkg::ADDR_INTERP_HI)
                begin
                    st_nxt.stage_hi = word[7:0];
                    cand_write = 1'b1;
                end
                if (word[14:8] == ecc_pkg::ADDR_INTERP_LO)
                begin
                    st_nxt.stage_lo = word[7:0];
                    cand_write = 1'b1;
                end
                if (word[14:8] == ecc_pkg::ADDR_COMMIT
                    && word[7:0] == ecc_pkg::COMMIT_KEY)
                begin
                    st_nxt.commit = 1'b1;
                end
            end
        end
        else if (fall && st_r.bits >= 5'h08)
        begin
            st_nxt.dout = st_r.rd_sh[7];
            st_nxt.rd_sh = {st_r.rd_sh[6:0], 1'b0};
        end
        if (cand_write)
        begin
            cand_factor = {st_nxt.stage_hi[ecc_pkg::HI_FACTOR_MSB:0],
                           st_nxt.stage_lo};
            cand_code = st_nxt.stage_hi[ecc_pkg::WCODE_LSB +: 2];
            // A half-written pair may pass through zero; hold the old one.
            if (cand_factor != 11'h000 && cand_factor <= ecc_pkg::FACTOR_MAX
                && cand_code != ecc_pkg::WCODE_BAD)
            begin
                st_nxt.factor = cand_factor;
                st_nxt.wcode = cand_code;
            end
        end

        // One shared blink keeps both 500 ms indicators in phase.
        if (st_r.blink_cnt >= BLINK_HALF - 24'h000001)
        begin
            st_nxt.blink_cnt = '0;
            st_nxt.blink = !st_r.blink;
        end
        else
        begin
            st_nxt.blink_cnt = st_r.blink_cnt + 24'h000001;
        end

        unique case (st_r.cal)
            ecc_pkg::ECC_PWR: st_nxt.cal = calib_request ?
                ecc_pkg::ECC_RUN : ecc_pkg::ECC_NORM;
            ecc_pkg::ECC_RUN:
                if (cal_evt.failed) st_nxt.cal = ecc_pkg::ECC_ERR;
                else if (cal_evt.inc_done) st_nxt.cal = ecc_pkg::ECC_INC;
            ecc_pkg::ECC_INC:
                if (cal_evt.failed) st_nxt.cal = ecc_pkg::ECC_ERR;
                else if (cal_evt.idx_done) st_nxt.cal = ecc_pkg::ECC_DONE;
            // Calibration end states are left only by reset.
            ecc_pkg::ECC_DONE: st_nxt.cal = ecc_pkg::ECC_DONE;
            ecc_pkg::ECC_ERR: st_nxt.cal = ecc_pkg::ECC_ERR;
            ecc_pkg::ECC_NORM: st_nxt.cal = ecc_pkg::ECC_NORM;
            default: st_nxt.cal = ecc_pkg::ECC_PWR;
        endcase

        st_nxt.quad = '0;
        st_nxt.ready = 1'b0;
        st_nxt.cal_ind = 1'b0;
        st_nxt.fault = 1'b0;
        unique case (st_r.cal)
            ecc_pkg::ECC_RUN: st_nxt.cal_ind = st_r.blink;
            ecc_pkg::ECC_INC:
            begin
                st_nxt.quad.a_pos = 1'b1;
                st_nxt.cal_ind = st_r.blink;
            end
            ecc_pkg::ECC_DONE:
            begin
                st_nxt.quad.b_pos = 1'b1;
                st_nxt.cal_ind = 1'b1;
            end
            ecc_pkg::ECC_ERR:
            begin
                st_nxt.quad.a_pos = 1'b1;
                st_nxt.quad.b_pos = 1'b1;
            end
            ecc_pkg::ECC_NORM:
            begin
                if (light_max_current)
                begin
                    st_nxt.quad = ecc_pkg::QUAD_FAULT;
                    st_nxt.fault = 1'b1;
                end
                else
                begin
                    st_nxt.quad = '{raw_a, !raw_a, raw_b, !raw_b,
                                    raw_index, !raw_index};
                    st_nxt.fault = light_high_warn && st_r.blink;
                    st_nxt.ready = !light_high_warn;
                end
            end
            default:
            begin
                st_nxt.quad = '0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '{ecc_pkg::ECC_PWR, 1'b0, 16'h0000, 5'h00, 8'h00, 1'b0,
                      ecc_pkg::STAGE_HI_RESET, ecc_pkg::STAGE_LO_RESET,
                      ecc_pkg::FACTOR_RESET, ecc_pkg::WCODE_90, 1'b0,
                      24'h000000, 1'b0, 6'h00, 1'b0, 1'b0, 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        unique case (st_r.wcode)
            ecc_pkg::WCODE_180: index_gate = ecc_pkg::ECC_GATE_180;
            ecc_pkg::WCODE_360: index_gate =
                (st_r.factor == ecc_pkg::FACTOR_1X) ?
                ecc_pkg::ECC_GATE_RAW : ecc_pkg::ECC_GATE_360;
            default: index_gate = ecc_pkg::ECC_GATE_90;
        endcase
    end

    assign spi_dout = st_r.dout;
    assign quad_out = st_r.quad;
    assign interp_factor = st_r.factor;
    assign cfg_commit = st_r.commit;
    assign ready_indicator = st_r.ready;
    assign calib_indicator = st_r.cal_ind;
    assign fault_indicator = st_r.fault;

    ////////////////////////////////////////////////////////////////////////
    a_factor_valid: assert property (@(posedge clk) disable iff (rst)
        interp_factor != 11'h000 && interp_factor <= ecc_pkg::FACTOR_MAX
        && st_r.wcode != ecc_pkg::WCODE_BAD)
        else $error("Interpolation setting left the legal range.");
    a_raw_at_1x: assert property (@(posedge clk) disable iff (rst)
        interp_factor == ecc_pkg::FACTOR_1X
        |-> index_gate != ecc_pkg::ECC_GATE_360)
        else $error("360 degree gating offered at 1X.");
    a_cal_start: assert property (@(posedge clk) disable iff (rst)
        st_r.cal == ecc_pkg::ECC_PWR && calib_request
        |=> st_r.cal == ecc_pkg::ECC_RUN)
        else $error("Calibration did not start on request.");
    a_cal_inc_out: assert property (@(posedge clk) disable iff (rst)
        st_r.cal == ecc_pkg::ECC_INC
        |=> quad_out.a_pos && !quad_out.b_pos && !quad_out.i_pos)
        else $error("Incremental calibration pattern wrong.");
    a_cal_err_out: assert property (@(posedge clk) disable iff (rst)
        st_r.cal == ecc_pkg::ECC_ERR
        |=> quad_out.a_pos && quad_out.b_pos && !quad_out.i_pos)
        else $error("Calibration error pattern wrong.");
    a_no_resume: assert property (@(posedge clk) disable iff (rst)
        st_r.cal == ecc_pkg::ECC_DONE |=> st_r.cal == ecc_pkg::ECC_DONE
        && !ready_indicator)
        else $error("Left calibration without power cycle.");
    a_cal_done_ind: assert property (@(posedge clk) disable iff (rst)
        st_r.cal == ecc_pkg::ECC_DONE [*2] |-> calib_indicator)
        else $error("Calibration indicator not high after completion.");
    a_ready_only: assert property (@(posedge clk) disable iff (rst)
        ready_indicator |-> $past(st_r.cal) == ecc_pkg::ECC_NORM
        && !fault_indicator)
        else $error("Ready shown outside encoder-ready state.");
    a_fault_pattern: assert property (@(posedge clk) disable iff (rst)
        st_r.cal == ecc_pkg::ECC_NORM && light_max_current
        |=> quad_out == ecc_pkg::QUAD_FAULT && fault_indicator)
        else $error("Off-scale fault pattern not driven.");
    a_commit_key: assert property (@(posedge clk) disable iff (rst)
        cfg_commit |-> $past(word[7:0]) == ecc_pkg::COMMIT_KEY
        && $past(st_r.bits) == 5'h0f)
        else $error("Commit pulse without key frame.");

endmodule

// ---- verification/ecc_host_model.sv ----
// Host controller model that drives the serial link of the encoder block.
// Assumes the bench clock; link pins change only at falling clk edges.
`timescale 1ns/100ps
module ecc_host_model (
    input wire logic clk,
    input wire logic spi_dout,
    output logic spi_sel_n,
    output logic spi_sclk,
    output logic spi_din
);
    initial
    begin
        spi_sel_n = 1'b1;
        spi_sclk = 1'b0;
        spi_din = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Ten clk per phase keeps the serial clock at 1 MHz.
    task automatic half();
        repeat (10) @(negedge clk);
    endtask

    task automatic xfer(input logic wr, input logic [6:0] a,
        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {wr, a, d};
        q = 8'h00;
        spi_sel_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            spi_din = f[i];
            half();
            if (i < 8)
                q[i] = spi_dout;
            spi_sclk = 1'b1;
            half();
            spi_sclk = 1'b0;
        end
        half();
        spi_sel_n = 1'b1;
        // A released line must not look like valid data.
        spi_din = ~spi_din;
        half();
    endtask
endmodule

// ---- verification/test_encoder_interp_config_calib_status.sv ----
// Bench for the encoder configuration, calibration and status block.
// Assumes ecc_pkg and the host model; blink half period shortened to 4.
`timescale 1ns/100ps
module test_encoder_interp_config_calib_status;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic spi_sel_n, spi_sclk, spi_din, spi_dout;
    logic calib_request = 1'b0;
    ecc_pkg::ecc_cal_evt_s cal_evt = '0;
    logic light_max_current = 1'b0;
    logic light_high_warn = 1'b0;
    logic raw_a = 1'b1;
    logic raw_b = 1'b0;
    logic raw_index = 1'b1;
    ecc_pkg::ecc_quad_s quad_out;
    logic [10:0] interp_factor;
    ecc_pkg::ecc_gate_e index_gate;
    logic cfg_commit, ready_indicator, calib_indicator, fault_indicator;
    int n_mismatch = 0;
    int checks = 0;
    int n_commit = 0;
    logic [7:0] rd;
    logic [2:0] status;
    logic [7:0] hi_tab [4] = '{8'h04, 8'h44, 8'hc4, 8'h84};
    logic [1:0] gate_tab [4] = '{2'h0, 2'h1, 2'h3, 2'h3};

    always #25 clk = ~clk;
    assign status = {ready_indicator, calib_indicator, fault_indicator};
    always @(posedge clk)
        if (cfg_commit === 1'b1)
            n_commit <= n_commit + 1;

    ecc_core #(.BLINK_HALF(24'h4)) u_dut (.clk(clk), .rst(rst),
        .spi_sel_n(spi_sel_n), .spi_sclk(spi_sclk), .spi_din(spi_din),
        .spi_dout(spi_dout), .calib_request(calib_request),
        .cal_evt(cal_evt), .light_max_current(light_max_current),
        .light_high_warn(light_high_warn), .raw_a(raw_a), .raw_b(raw_b),
        .raw_index(raw_index), .quad_out(quad_out),
        .interp_factor(interp_factor), .index_gate(index_gate),
        .cfg_commit(cfg_commit), .ready_indicator(ready_indicator),
        .calib_indicator(calib_indicator),
        .fault_indicator(fault_indicator));
    ecc_host_model u_host (.clk(clk), .spi_dout(spi_dout),
        .spi_sel_n(spi_sel_n), .spi_sclk(spi_sclk), .spi_din(spi_din));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [10:0] s,
        input logic [10:0] e);
        checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, d, rd);
    endtask

    task automatic pwr(input logic cal);
        rst = 1'b1;
        calib_request = cal;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic ev(input logic [2:0] e);
        cal_evt = e;
        @(negedge clk);
        cal_evt = '0;
        // Calibration events are pulsed, so the long host wait shrinks here.
        repeat (3) @(negedge clk);
    endtask

    // Counts indicator edges over 40 cycles after one settling cycle.
    // The switch-on edge is skipped, so four-cycle halves give ten edges.
    task automatic blink(input string n, input logic f);
        int t;
        logic p;
        t = 0;
        @(negedge clk);
        p = f ? fault_indicator : calib_indicator;
        repeat (40)
        begin
            @(negedge clk);
            if ((f ? fault_indicator : calib_indicator) !== p)
                t++;
            p = f ? fault_indicator : calib_indicator;
        end
        chk(n, 11'(t), 11'h00a);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        repeat (3) @(negedge clk);
        chk("st_rst", 11'(status), 11'h000);
        pwr(1'b0);
        chk("ready", 11'(ready_indicator), 11'h001);
        chk("raw", 11'(quad_out), 11'h026);
        wr(7'h10, 8'hab);
        wr(7'h14, 8'h00);
        wr(7'h0c, 8'h00);
        chk("fac_zero", interp_factor, 11'h001);
        wr(7'h0b, 8'h01);
        chk("fac_256", interp_factor, 11'h100);
        wr(7'h0b, 8'h02);
        chk("fac_512", interp_factor, 11'h200);
        for (int i = 0; i < 4; i++)
        begin
            wr(7'h0b, hi_tab[i]);
            chk("gate", 11'(index_gate), 11'(gate_tab[i]));
            chk("fac_1024", interp_factor, 11'h400);
        end
        wr(7'h0c, 8'h05);
        chk("fac_big", interp_factor, 11'h400);
        u_host.xfer(1'b0, 7'h0c, 8'h00, rd);
        chk("rd_lo", 11'(rd), 11'h005);
        u_host.xfer(1'b0, 7'h0b, 8'h00, rd);
        chk("rd_hi", 11'(rd), 11'h084);
        wr(7'h0b, 8'hc0);
        wr(7'h0c, 8'h01);
        chk("fac_1x", interp_factor, 11'h001);
        chk("gate_1x", 11'(index_gate), 11'(ecc_pkg::ECC_GATE_RAW));
        n_commit = 0;
        wr(7'h11, 8'ha1);
        chk("commit", 11'(n_commit), 11'h001);
        light_high_warn = 1'b1;
        blink("warn", 1'b1);
        chk("rdy_warn", 11'(ready_indicator), 11'h000);
        light_high_warn = 1'b0;
        light_max_current = 1'b1;
        repeat (3) @(negedge clk);
        chk("q_fault", 11'(quad_out), 11'(ecc_pkg::QUAD_FAULT));
        chk("fault", 11'(status), 11'h001);
        light_max_current = 1'b0;
        pwr(1'b1);
        chk("q_run", 11'(quad_out), 11'h000);
        chk("rdy_cal", 11'(ready_indicator), 11'h000);
        blink("cal", 1'b0);
        ev(3'h4);
        chk("q_inc", 11'(quad_out), 11'h020);
        ev(3'h2);
        chk("q_done", 11'(quad_out), 11'h008);
        chk("cal_done", 11'(calib_indicator), 11'h001);
        calib_request = 1'b0;
        repeat (5) @(negedge clk);
        chk("hold", 11'({quad_out, ready_indicator}), 11'h010);
        pwr(1'b1);
        ev(3'h1);
        chk("q_err", 11'(quad_out), 11'h028);
        chk("cal_err", 11'(status), 11'h000);
        pwr(1'b0);
        chk("rdy_back", 11'(ready_indicator), 11'h001);
        raw_a = 1'b0;
        raw_b = 1'b1;
        raw_index = 1'b0;
        repeat (2) @(negedge clk);
        chk("raw_flip", 11'(quad_out), 11'h019);
        conclude();
    end
endmodule
